//--- src/bbg_regs.svh
// Purpose: register offsets, bit positions and reset values of the backup gating block
// Assumes: byte addresses on a 32-bit classic Wishbone bus, data in the low byte
// Notes: included by bare name
`ifndef BBG_REGS_SVH
`define BBG_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define BBG_OFS_CTRL 8'h00
`define BBG_OFS_ALM_SEC 8'h04
`define BBG_OFS_ALM_MIN 8'h08
`define BBG_OFS_STATUS 8'h0C
`define BBG_OFS_INT_EN 8'h10
`define BBG_OFS_INT_CLR 8'h14
`define BBG_OFS_POWER 8'h18

// ----------------------------------------
// control fields
// ----------------------------------------
`define BBG_CTRL_SWITCH 0
`define BBG_CTRL_INHIBIT 1
`define BBG_CTRL_REPEAT 2
`define BBG_CTRL_ALM_EN 3

// ----------------------------------------
// status and interrupt fields
// ----------------------------------------
`define BBG_ST_ALARM 0
`define BBG_ST_BLOCKED 1

// ----------------------------------------
// power state fields
// ----------------------------------------
`define BBG_PW_BACKUP 0
`define BBG_PW_BUS 1
`define BBG_PW_NVM 2
`define BBG_PW_FREQ 3
`define BBG_PW_LVR 4

// ----------------------------------------
// reset values and field layout
// ----------------------------------------
`define BBG_CTRL_RST 8'h01
`define BBG_ALM_RST 8'h00
`define BBG_ALM_FIELD_EN 7

`endif

//--- src/bbg_pkg.sv
// Purpose: shared types of the backup gating block
// Assumes: nothing beyond the register header
// Notes: mode order follows {inhibit, switchover} as a two-bit number
package bbg_pkg;

   // mode a: standard, blocked; b: legacy, bus on battery; c: standard, output kept; d: legacy, blocked
   typedef enum logic [1:0] {
      BBG_MODE_A,
      BBG_MODE_B,
      BBG_MODE_C,
      BBG_MODE_D
   } bbg_mode_e;

endpackage

//--- src/bbg_alarm_match.sv
// Purpose: alarm 0 compare of seconds and minutes with single or repeating events
// Assumes: time fields arrive as BCD, sampled on the one-second tick
// Notes: a disarmed single alarm is armed again by i_rearm
`timescale 1ns/1ns
`default_nettype none
`include "bbg_regs.svh"

module bbg_alarm_match (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_tick,
   input wire logic i_enable,
   input wire logic i_repeat,
   input wire logic i_rearm,
   input wire logic [7:0] i_sec_compare,
   input wire logic [7:0] i_min_compare,
   input wire logic [6:0] i_time_sec,
   input wire logic [6:0] i_time_min,
   output logic o_event
);

   logic [7:0] cmp [2];
   logic [6:0] now [2];
   logic [1:0] field_on;
   logic [1:0] field_hit;
   logic armed;
   logic match;
   logic fire;

   assign cmp[0] = i_sec_compare;
   assign cmp[1] = i_min_compare;
   assign now[0] = i_time_sec;
   assign now[1] = i_time_min;

   // ----------------------------------------
   // field compare
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_field
         assign field_on[g] = cmp[g][`BBG_ALM_FIELD_EN];
         assign field_hit[g] = !field_on[g] || (cmp[g][6:0] == now[g]);
      end
   endgenerate

   // an alarm with every field disabled never fires
   assign match = (|field_on) && (&field_hit);
   assign fire = i_tick && i_enable && match && (armed || i_repeat);

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         armed <= 1'b1;
         o_event <= 1'b0;
      end else begin
         o_event <= fire;
         if (i_rearm) begin
            armed <= 1'b1;
         end else if (fire && !i_repeat) begin
            armed <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   sequence s_single_fire;
      fire && !i_repeat && !i_rearm;
   endsequence

   single_alarm_disarm_a: assert property (s_single_fire |=> !armed ##0 (!fire || i_repeat))
      else $error("single alarm did not disarm");
   field_disable_a: assert property (!i_sec_compare[7] && i_min_compare[7]
         && (i_min_compare[6:0] == i_time_min) && i_tick && i_enable && armed |=> o_event)
      else $error("disabled field blocked a match");

endmodule
`default_nettype wire

//--- src/bbg_backup_gating.sv
// Purpose: picks battery backup behaviour and gates serial bus, memory and output enables
// Assumes: supply comparator levels arrive synchronous to i_core_clk
// Notes: all enables are registered, one cycle behind the comparators
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "bbg_regs.svh"

// How it works
// - main supply below reset threshold always stops the serial bus.
// - mode a switches at trip threshold, blocks bus and memory on backup.
// - mode b switches below battery, bus on backup only if battery above reset.
// - mode c switches like mode a but keeps frequency/interrupt output active.
// - mode d switches below battery, bus only with valid main supply.
// - single alarm mode gives one event per arming, not a repeating pulse.
// - alarm byte bit 7 enables the field, low bits hold the BCD value.
// - after reset the legacy switchover mode is selected.
module bbg_backup_gating (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_vdd_below_reset,
   input wire logic i_vdd_below_trip,
   input wire logic i_vdd_below_bat,
   input wire logic i_bat_above_reset,
   input wire logic i_sec_tick,
   input wire logic [6:0] i_time_sec,
   input wire logic [6:0] i_time_min,
   output logic o_on_backup,
   output logic o_serial_bus_enable,
   output logic o_bus_idle_hold,
   output logic o_nvm_access_enable,
   output logic o_freq_enable,
   output logic o_freq_or_interrupt_out,
   output logic o_low_voltage_reset,
   output logic o_alarm0_event,
   output logic o_irq
);

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic is_legacy(input bbg_pkg::bbg_mode_e m);
      is_legacy = (m == bbg_pkg::BBG_MODE_B) || (m == bbg_pkg::BBG_MODE_D);
   endfunction

   function automatic logic bus_on_battery(input bbg_pkg::bbg_mode_e m);
      bus_on_battery = (m == bbg_pkg::BBG_MODE_B);
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic switchover_select;
   logic backup_bus_inhibit;
   logic alarm_repeat_mode;
   logic alarm_enable;
   logic [7:0] alarm0_seconds_compare;
   logic [7:0] alarm0_minutes_compare;
   logic [1:0] status;
   logic [1:0] int_en;
   logic alarm_event;
   logic bus_prev;
   // control byte after reset: legacy switchover, alarm off
   localparam logic [7:0] CTRL_RST = `BBG_CTRL_RST;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   wire wr = req && i_wb_we && i_wb_sel[0];
   wire wr_ctrl = wr && (i_wb_adr == `BBG_OFS_CTRL);
   wire wr_sec = wr && (i_wb_adr == `BBG_OFS_ALM_SEC);
   wire wr_min = wr && (i_wb_adr == `BBG_OFS_ALM_MIN);
   wire wr_en = wr && (i_wb_adr == `BBG_OFS_INT_EN);
   wire wr_clr = wr && (i_wb_adr == `BBG_OFS_INT_CLR);
   wire [1:0] clr_bits = wr_clr ? i_wb_dat[1:0] : 2'h0;

   // ----------------------------------------
   // mode and gating
   // ----------------------------------------
   wire bbg_pkg::bbg_mode_e mode = bbg_pkg::bbg_mode_e'({backup_bus_inhibit, switchover_select});
   // standard modes switch at the trip point, legacy ones when main drops below battery
   wire next_on_backup = is_legacy(mode) ? i_vdd_below_bat : i_vdd_below_trip;
   // below reset the bus is dead in every mode, whatever the mode bits promise
   wire next_bus = !i_vdd_below_reset
                   && (!next_on_backup || (bus_on_battery(mode) && i_bat_above_reset));
   wire next_nvm = next_bus;
   wire next_freq = (mode != bbg_pkg::BBG_MODE_A) || !next_on_backup;
   wire next_blocked_evt = bus_prev && !next_bus;
   wire [1:0] events = {next_blocked_evt, alarm_event};
   // set wins over a clear in the same cycle
   wire [1:0] next_status = (status & ~clr_bits) | events;
   wire next_irq = |(next_status & int_en);

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   logic [7:0] rd_byte;
   always_comb begin
      unique case (i_wb_adr)
         `BBG_OFS_CTRL: rd_byte = {4'h0, alarm_enable, alarm_repeat_mode, backup_bus_inhibit, switchover_select};
         `BBG_OFS_ALM_SEC: rd_byte = alarm0_seconds_compare;
         `BBG_OFS_ALM_MIN: rd_byte = alarm0_minutes_compare;
         `BBG_OFS_STATUS: rd_byte = {6'h00, status};
         `BBG_OFS_INT_EN: rd_byte = {6'h00, int_en};
         `BBG_OFS_POWER: rd_byte = {3'h0, o_low_voltage_reset, o_freq_enable, o_nvm_access_enable,
                                    o_serial_bus_enable, o_on_backup};
         default: rd_byte = 8'h00;
      endcase
   end

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= req;
         o_wb_dat <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         switchover_select <= CTRL_RST[`BBG_CTRL_SWITCH];
         backup_bus_inhibit <= CTRL_RST[`BBG_CTRL_INHIBIT];
         alarm_repeat_mode <= CTRL_RST[`BBG_CTRL_REPEAT];
         alarm_enable <= CTRL_RST[`BBG_CTRL_ALM_EN];
      end else if (wr_ctrl) begin
         switchover_select <= i_wb_dat[`BBG_CTRL_SWITCH];
         backup_bus_inhibit <= i_wb_dat[`BBG_CTRL_INHIBIT];
         alarm_repeat_mode <= i_wb_dat[`BBG_CTRL_REPEAT];
         alarm_enable <= i_wb_dat[`BBG_CTRL_ALM_EN];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         alarm0_seconds_compare <= `BBG_ALM_RST;
         alarm0_minutes_compare <= `BBG_ALM_RST;
         int_en <= 2'h0;
      end else begin
         if (wr_sec) begin
            alarm0_seconds_compare <= i_wb_dat[7:0];
         end
         if (wr_min) begin
            alarm0_minutes_compare <= i_wb_dat[7:0];
         end
         if (wr_en) begin
            int_en <= i_wb_dat[1:0];
         end
      end
   end

   // ----------------------------------------
   // power gating outputs and interrupts
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_on_backup <= 1'b0;
         o_serial_bus_enable <= 1'b0;
         o_bus_idle_hold <= 1'b1;
         o_nvm_access_enable <= 1'b0;
         o_freq_enable <= 1'b0;
         o_low_voltage_reset <= 1'b1;
         o_freq_or_interrupt_out <= 1'b0;
         bus_prev <= 1'b0;
         status <= 2'h0;
         o_irq <= 1'b0;
         o_alarm0_event <= 1'b0;
      end else begin
         o_on_backup <= next_on_backup;
         o_serial_bus_enable <= next_bus;
         o_bus_idle_hold <= !next_bus;
         o_nvm_access_enable <= next_nvm;
         o_freq_enable <= next_freq;
         o_low_voltage_reset <= i_vdd_below_reset;
         o_freq_or_interrupt_out <= next_irq && next_freq;
         bus_prev <= next_bus;
         status <= next_status;
         o_irq <= next_irq;
         o_alarm0_event <= alarm_event;
      end
   end

   // ----------------------------------------
   // alarm 0
   // ----------------------------------------
   // any write to the alarm setup arms a single alarm again
   bbg_alarm_match u_alarm (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_tick(i_sec_tick),
      .i_enable(alarm_enable),
      .i_repeat(alarm_repeat_mode),
      .i_rearm(wr_ctrl || wr_sec || wr_min),
      .i_sec_compare(alarm0_seconds_compare),
      .i_min_compare(alarm0_minutes_compare),
      .i_time_sec(i_time_sec),
      .i_time_min(i_time_min),
      .o_event(alarm_event)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   sequence s_mode_a_backup;
      !backup_bus_inhibit && !switchover_select && i_vdd_below_trip;
   endsequence

   sequence s_mode_b_battery_ok;
      !backup_bus_inhibit && switchover_select && i_vdd_below_bat && !i_vdd_below_reset && i_bat_above_reset;
   endsequence

   // a request is taken when strobed and not already being answered
   sequence s_wb_take;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence

   sequence s_bus_cut;
      o_serial_bus_enable && i_vdd_below_reset;
   endsequence

   sequence s_mode_d_valid;
      backup_bus_inhibit && switchover_select && !i_vdd_below_bat && !i_vdd_below_reset;
   endsequence

   bus_cut_reset_a: assert property (i_vdd_below_reset |=> !o_serial_bus_enable && o_low_voltage_reset)
      else $error("bus alive below reset threshold");
   mode_a_block_a: assert property (s_mode_a_backup |=> o_on_backup && !o_serial_bus_enable
         && !o_nvm_access_enable && !o_freq_enable)
      else $error("mode a left access open on backup");
   mode_b_bus_a: assert property (s_mode_b_battery_ok |=> o_on_backup && o_serial_bus_enable
         && o_nvm_access_enable && o_freq_enable)
      else $error("mode b blocked a valid battery access");
   mode_c_freq_a: assert property (backup_bus_inhibit && !switchover_select && i_vdd_below_trip
         |=> o_freq_enable && !o_serial_bus_enable && o_on_backup)
      else $error("mode c output or bus wrong on backup");
   mode_d_block_a: assert property (backup_bus_inhibit && switchover_select && i_vdd_below_bat
         |=> !o_serial_bus_enable && !o_nvm_access_enable)
      else $error("mode d allowed bus on backup");
   reset_legacy_a: assert property (disable iff (1'b0) i_rst ##1 !i_rst |-> switchover_select
         && !backup_bus_inhibit)
      else $error("reset did not select legacy mode");
   idle_hold_a: assert property (o_bus_idle_hold == !o_serial_bus_enable)
      else $error("bus hold disagrees with access");
   alarm_status_a: assert property (alarm_event |=> status[`BBG_ST_ALARM] && o_alarm0_event)
      else $error("alarm event lost");
   ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held two cycles");

   // ----------------------------------------
   // bus, status and supply checks
   // ----------------------------------------
   ack_answer_a: assert property (s_wb_take |=> o_wb_ack)
      else $error("bus request not answered");
   dat_idle_zero_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
      else $error("read data outside an answer");
   reset_release_a: assert property (!i_vdd_below_reset |=> !o_low_voltage_reset)
      else $error("supply reset held with good supply");
   blocked_event_a: assert property (s_bus_cut |=> status[`BBG_ST_BLOCKED] && o_bus_idle_hold)
      else $error("bus cut not recorded");
   standard_switch_a: assert property (!switchover_select && !i_vdd_below_trip |=> !o_on_backup)
      else $error("standard mode left main supply early");
   legacy_switch_a: assert property (switchover_select && !i_vdd_below_bat |=> !o_on_backup)
      else $error("legacy mode left main supply early");
   mode_b_weak_a: assert property (!backup_bus_inhibit && switchover_select && i_vdd_below_bat
         && !i_bat_above_reset |=> !o_serial_bus_enable)
      else $error("mode b bus open on a weak battery");
   mode_c_main_a: assert property (backup_bus_inhibit && !switchover_select && !i_vdd_below_trip
         && !i_vdd_below_reset |=> o_serial_bus_enable && !o_on_backup)
      else $error("mode c blocked a valid main supply");
   mode_d_valid_a: assert property (s_mode_d_valid |=> o_serial_bus_enable && !o_on_backup)
      else $error("mode d blocked a valid main supply");
   nvm_follows_a: assert property (o_nvm_access_enable == o_serial_bus_enable)
      else $error("memory access differs from bus access");
   freq_pin_gate_a: assert property (!o_freq_enable |-> !o_freq_or_interrupt_out)
      else $error("interrupt pin driven while output disabled");
   // a set in the same cycle as a clear still wins
   set_wins_a: assert property (alarm_event && clr_bits[`BBG_ST_ALARM] |=> status[`BBG_ST_ALARM])
      else $error("alarm flag lost to a clear");
   status_sticky_a: assert property (status[`BBG_ST_ALARM] && !clr_bits[`BBG_ST_ALARM]
         |=> status[`BBG_ST_ALARM])
      else $error("alarm flag dropped without a clear");
   irq_level_a: assert property ($stable(int_en) |-> o_irq == |(status & int_en))
      else $error("interrupt level disagrees with enabled status");

endmodule
`default_nettype wire

//--- tb/bbg_host_model.sv
// Purpose: two-wire host that frames traffic only while the device lets it
// Assumes: enable and idle hold come from the gating block
// Notes: a frame cut short by a blocked bus counts as aborted
`timescale 1ns/1ns
`default_nettype none

module bbg_host_model (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_bus_enable,
   input wire logic i_idle_hold,
   output logic [7:0] o_frames,
   output logic [7:0] o_aborts,
   output logic o_conflict
);
   logic [3:0] bit_cnt;

   // ----------------------------------------
   // frame sequencer
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         bit_cnt <= 4'h0;
         o_frames <= 8'h00;
         o_aborts <= 8'h00;
         o_conflict <= 1'b0;
      end else begin
         if (i_bus_enable === i_idle_hold) begin
            o_conflict <= 1'b1;
         end
         if (bit_cnt != 4'h0 && i_bus_enable !== 1'b1) begin
            bit_cnt <= 4'h0;
            o_aborts <= o_aborts + 8'h01;
         end else if (bit_cnt == 4'h9) begin
            bit_cnt <= 4'h0;
            o_frames <= o_frames + 8'h01;
         end else if (bit_cnt != 4'h0 || i_bus_enable === 1'b1) begin
            bit_cnt <= bit_cnt + 4'h1;
         end
      end
   end
endmodule

`default_nettype wire

//--- tb/tb_bbg_backup_gating.sv
// Purpose: self-checking bench of the backup gating block
// Assumes: one clock, synchronous reset, classic Wishbone registers
// Notes: mode table in rows, alarm and interrupt cases by hand
`timescale 1ns/1ns
`default_nettype none
`include "bbg_regs.svh"

module tb_bbg_backup_gating;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic ack, r, t, b, a, tick = 1'b0;
   logic [6:0] tsec = 7'h00;
   logic [6:0] tmin = 7'h00;
   logic [7:0] seen_cnt;
   logic on_bk, bus_en, idle, nvm, freq_en, fout, lv_rst, alm, irq;
   logic [7:0] frames, aborts;
   logic conflict;
   logic [31:0] ev_cnt = 32'h0;
   int err_count = 0, n_tests = 0;
   // rows: {inhibit,switch}, {below_reset,below_trip,below_bat,bat_above_reset}, power
   localparam logic [10:0] ROWS [10] = '{
      {2'h0, 4'b0000, 5'h0E}, {2'h0, 4'b1111, 5'h11}, {2'h0, 4'b0100, 5'h01},
      {2'h1, 4'b0011, 5'h0F}, {2'h1, 4'b0010, 5'h09}, {2'h1, 4'b1011, 5'h19},
      {2'h2, 4'b0100, 5'h09}, {2'h2, 4'b0010, 5'h0E}, {2'h3, 4'b0011, 5'h09},
      {2'h3, 4'b0100, 5'h0E}};

   always #10 i_core_clk = ~i_core_clk;
   initial {r, t, b, a} = 4'b0001;

   bbg_backup_gating bbg_backup_gating_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_vdd_below_reset(r), .i_vdd_below_trip(t), .i_vdd_below_bat(b),
      .i_bat_above_reset(a), .i_sec_tick(tick), .i_time_sec(tsec), .i_time_min(tmin),
      .o_on_backup(on_bk), .o_serial_bus_enable(bus_en), .o_bus_idle_hold(idle),
      .o_nvm_access_enable(nvm), .o_freq_enable(freq_en), .o_freq_or_interrupt_out(fout),
      .o_low_voltage_reset(lv_rst), .o_alarm0_event(alm), .o_irq(irq));
   bbg_host_model bbg_host_model_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus_enable(bus_en),
      .i_idle_hold(idle), .o_frames(frames), .o_aborts(aborts), .o_conflict(conflict));

   always @(posedge i_core_clk) begin
      if (alm === 1'b1) begin
         ev_cnt <= ev_cnt + 32'h1;
      end
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge i_core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      sel <= 4'hF;
      wdat <= {24'h0, d};
      do begin
         @(posedge i_core_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         err_count++;
         summarize();
      end
   endtask

   task automatic sec_tick(input logic [6:0] s);
      @(posedge i_core_clk);
      tsec <= s;
      tick <= 1'b1;
      @(posedge i_core_clk);
      tick <= 1'b0;
      repeat (4) @(posedge i_core_clk);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge i_core_clk);
      i_rst <= 1'b0;
      wb(1'b0, `BBG_OFS_CTRL, 8'h00);
      check(rd, 32'h01);
      wb(1'b0, `BBG_OFS_POWER, 8'h00);
      check(rd, 32'h0E);
      for (int i = 0; i < 10; i++) begin
         wb(1'b1, `BBG_OFS_CTRL, {6'h0, ROWS[i][10:9]});
         {r, t, b, a} <= ROWS[i][8:5];
         repeat (12) @(posedge i_core_clk);
         check({lv_rst, freq_en, nvm, bus_en, on_bk}, ROWS[i][4:0]);
         check({31'h0, idle}, {31'h0, ~ROWS[i][1]});
         wb(1'b0, `BBG_OFS_POWER, 8'h00);
         check(rd, {27'h0, ROWS[i][4:0]});
      end
      {r, t, b, a} <= 4'b0001;
      wb(1'b1, `BBG_OFS_INT_CLR, 8'h03);
      wb(1'b1, `BBG_OFS_INT_EN, 8'h01);
      wb(1'b1, `BBG_OFS_ALM_MIN, 8'h00);
      wb(1'b1, `BBG_OFS_ALM_SEC, 8'hB0);
      wb(1'b1, `BBG_OFS_CTRL, 8'h09);
      sec_tick(7'h30);
      sec_tick(7'h30);
      check(ev_cnt, 32'h1);
      check(irq, 1'b1);
      check(fout, 1'b1);
      wb(1'b0, `BBG_OFS_STATUS, 8'h00);
      check(rd, 32'h01);
      wb(1'b1, `BBG_OFS_INT_CLR, 8'h01);
      @(posedge i_core_clk);
      check(irq, 1'b0);
      check(fout, 1'b0);
      wb(1'b1, `BBG_OFS_CTRL, 8'h0D);
      sec_tick(7'h30);
      sec_tick(7'h30);
      sec_tick(7'h31);
      check(ev_cnt, 32'h3);
      wb(1'b1, `BBG_OFS_INT_EN, 8'h00);
      sec_tick(7'h30);
      check(irq, 1'b0);
      wb(1'b1, `BBG_OFS_ALM_SEC, 8'h00);
      sec_tick(7'h00);
      sec_tick(7'h30);
      check(ev_cnt, 32'h4);
      wb(1'b1, `BBG_OFS_ALM_MIN, 8'h81);
      sec_tick(7'h00);
      check(ev_cnt, 32'h4);
      tmin <= 7'h01;
      sec_tick(7'h00);
      check(ev_cnt, 32'h5);
      // cut main supply just after a frame starts: the host must abort it
      seen_cnt = frames;
      for (int k = 0; k < 30 && frames == seen_cnt; k++) begin
         @(posedge i_core_clk);
      end
      if (frames == seen_cnt) begin
         err_count++;
         summarize();
      end
      seen_cnt = aborts;
      r <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      check(aborts, seen_cnt + 8'h01);
      check({31'h0, idle}, 32'h1);
      wb(1'b0, `BBG_OFS_STATUS, 8'h00);
      check(rd[`BBG_ST_BLOCKED], 1'b1);
      r <= 1'b0;
      wb(1'b0, 8'h40, 8'h00);
      check(rd, 32'h0);
      check(conflict, 1'b0);
      check(frames != 8'h00, 1'b1);
      // second reset in mid-run must bring legacy switchover back
      i_rst <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      check({31'h0, idle}, 32'h1);
      i_rst <= 1'b0;
      wb(1'b0, `BBG_OFS_CTRL, 8'h00);
      check(rd, 32'h01);
      summarize();
   end
endmodule

`default_nettype wire
